/* hw/asp_pkg.sv */
// Package for the async serial port engine (10-bit and 11-bit frame modes)
// Assumes an AHB-Lite master with single word transfers and one 10 MHz clock
package asp_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] BUF_OFF     = 8'h04;
    localparam logic [7:0] BAUD_OFF    = 8'h08;
    localparam logic [7:0] STAT_OFF    = 8'h0c;

    // Control register field positions
    localparam int unsigned RX_DONE_POS   = 0;
    localparam int unsigned TX_DONE_POS   = 1;
    localparam int unsigned RX_NINTH_POS  = 2;
    localparam int unsigned TX_NINTH_POS  = 3;
    localparam int unsigned RX_EN_POS     = 4;
    localparam int unsigned FILTER_POS    = 5;
    localparam int unsigned MODE_LO_POS   = 6;
    localparam int unsigned MODE_HI_POS   = 7;
    localparam int unsigned BAUD_DBL_POS  = 8;
    localparam int unsigned TX_SRC_POS    = 9;
    localparam int unsigned RX_SRC_POS    = 10;

    // Reset values
    localparam logic [10:0] CTRL_RST      = 11'h000;
    localparam logic [15:0] DIV_RST       = 16'h0001;
    localparam logic [8:0]  RX_SHIFT_INIT = 9'h1ff;

    // Oversampling and sample window
    localparam logic [3:0]  SAMPLE_A      = 4'h7;
    localparam logic [3:0]  SAMPLE_C      = 4'h9;
    // Oscillator divide for the fixed-rate mode's 16x tick: 32/16 = 2, 64/16 = 4
    localparam logic [1:0]  FIXED_DIV_FAST = 2'h1;
    localparam logic [1:0]  FIXED_DIV_SLOW = 2'h3;

    typedef enum logic [1:0] {
        ASP_MODE_SHIFT = 2'b00,
        ASP_MODE_10V   = 2'b01,
        ASP_MODE_11F   = 2'b10,
        ASP_MODE_11V   = 2'b11
    } asp_mode_e;

    typedef struct packed {
        logic       baud_double;
        logic       tx_clock_source_select;
        logic       rx_clock_source_select;
        logic [1:0] mode;
        logic       multiproc_filter_enable;
        logic       rx_enable;
        logic       tx_ninth_bit;
    } asp_cfg_s;

endpackage : asp_pkg

/* hw/asp_tick.sv */
// Divider producing a one-cycle 16x baud tick from a reload count
// Assumes the reload value is static while the port is in use
`timescale 1ns/10ps
`default_nettype none
module asp_tick #(
    parameter int unsigned W = 16
) (
    input  wire logic         hclk,    // System clock
    input  wire logic         hresetn, // Async reset, active low
    input  wire logic [W-1:0] reload,  // Cycles per tick minus one
    output logic              tick     // One-cycle tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } asp_tick_s;

    asp_tick_s q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == '0) begin
            d.cnt  = reload;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : asp_tick
`default_nettype wire

/* hw/asp_core.sv */
// Async serial port engine: 10-bit and 11-bit frame modes with AHB-Lite registers
// Assumes one 10 MHz clock and an external receive pin that is asynchronous
//
// Summary of operation
// - 10-bit mode: buffer write loads ninth position, frame starts at next rollover
// - Start bit first, shifter output one bit later, first shift one bit after
// - 10-bit mode: shift out LSB first, zero fill, final shift at marker pattern
// - Receiver starts on falling edge, watching the synchronised input every clock cycle
// - On edge preload shift register with ones and reset receive counter
// - Sample states seven, eight, nine per bit and take majority
// - Start bit not zero: abandon and resume edge search
// - 10-bit mode: commit when flag clear and filter off or stop bit one
// - 10-bit commit stores stop bit, data and sets flag; else discard
// - 11-bit frame: start, eight data LSB first, ninth bit, stop
// - 11-bit modes: transmit ninth from control bit, receive into ninth flag
// - Fixed-rate 11-bit mode runs at oscillator over 32 or 64
// - Variable 11-bit mode uses per-direction selected timer source
// - 11-bit modes: frame starts after next rollover with start bit
// - 11-bit modes: stop one shifted in, final shift sets transmit flag
// - 11-bit commit when flag clear and filter off or ninth bit one
// - 11-bit receive ignores stop bit, resumes search one bit later
// - Mode bits: 00 shift, 01 10-bit, 10 11-bit fixed, 11 11-bit variable
// - Reception starts only while receive enable is one
// - Transmit flag set as stop bit starts; only software clears it
// - Baud doubling zero after reset selects oscillator over 64
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module asp_core #(
    parameter int unsigned DIV_W = 16
) (
    input  wire logic        hclk,      // System clock
    input  wire logic        hresetn,   // Async reset, active low
    input  wire logic        hsel,      // Slave select
    input  wire logic [31:0] haddr,     // Address
    input  wire logic [1:0]  htrans,    // Transfer type
    input  wire logic        hwrite,    // Write
    input  wire logic [2:0]  hsize,     // Size
    input  wire logic        hready,    // Bus ready in
    input  wire logic [31:0] hwdata,    // Write data
    output logic [31:0]      hrdata,    // Read data
    output logic             hreadyout, // Slave ready
    output logic             hresp,     // Response, always OKAY
    input  wire logic        rxd_pin,   // Serial input
    output logic             txd_pin    // Serial output
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA} asp_tx_e;
    typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_TAIL} asp_rx_e;

    typedef struct packed {
        asp_pkg::asp_cfg_s cfg;
        logic              tx_done_flag;
        logic              rx_done_flag;
        logic              rx_ninth_bit;
        logic [7:0]        serial_buffer;
        logic [DIV_W-1:0]  div_t1;
        logic [DIV_W-1:0]  div_t2;
        logic              ap_valid;
        logic              ap_write;
        logic [7:0]        ap_addr;
        logic [31:0]       rdata;
        asp_tx_e           tx_st;
        logic [8:0]        tx_sh;
        logic [3:0]        tx_cnt;
        logic              tx_req;
        logic              tx_first;
        logic              txd;
        asp_rx_e           rx_st;
        logic [8:0]        rx_sh;
        logic [3:0]        rx_cnt;
        logic [2:0]        smp;
        logic              rx_s1;
        logic              rx_s2;
        logic              rx_prev;
        logic [1:0]        fix_cnt;
    } asp_core_s;

    asp_core_s q, d;
    logic      tick_t1;
    logic      tick_t2;

    // Two timer stand-ins, each a reloadable 16x tick source
    asp_tick #(.W(DIV_W)) u_t1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .reload  (q.div_t1),
        .tick    (tick_t1)
    );
    asp_tick #(.W(DIV_W)) u_t2 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .reload  (q.div_t2),
        .tick    (tick_t2)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic       fix_tick;
    logic       tx_tick;
    logic       rx_tick;
    logic       mode_on;
    logic       eleven;
    logic       wr_buf;
    logic [1:0] fix_lim;
    logic       vote;
    logic       rx_bit;
    logic       commit;
    logic [7:0] rx_rev;

    always_comb begin
        fix_lim = q.cfg.baud_double ? asp_pkg::FIXED_DIV_FAST
                                    : asp_pkg::FIXED_DIV_SLOW;
        fix_tick = (q.fix_cnt == fix_lim);
        mode_on  = (q.cfg.mode != asp_pkg::ASP_MODE_SHIFT);
        eleven   = q.cfg.mode[1];
        if (q.cfg.mode == asp_pkg::ASP_MODE_11F) begin
            tx_tick = fix_tick;
            rx_tick = fix_tick;
        end else begin
            tx_tick = q.cfg.tx_clock_source_select ? tick_t2 : tick_t1;
            rx_tick = q.cfg.rx_clock_source_select ? tick_t2 : tick_t1;
        end
        vote   = (q.smp[0] & q.smp[1]) | (q.smp[0] & q.smp[2]) | (q.smp[1] & q.smp[2]);
        rx_bit = vote;
        wr_buf = q.ap_valid && q.ap_write && (q.ap_addr == asp_pkg::BUF_OFF);
        commit = !q.rx_done_flag && (!q.cfg.multiproc_filter_enable || rx_bit);
    end

    // Receive shifter holds the first data bit leftmost; the buffer wants it in bit 0
    for (genvar gi = 0; gi < 8; gi++) begin : g_rx_rev
        assign rx_rev[gi] = q.rx_sh[7-gi];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.fix_cnt = fix_tick ? 2'h0 : q.fix_cnt + 2'h1;
        d.rx_s1   = rxd_pin;
        d.rx_s2   = q.rx_s1;
        d.rx_prev = q.rx_s2;

        // Bus: capture address phase, act on data phase
        d.ap_valid = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            d.ap_write = hwrite;
            d.ap_addr  = {haddr[7:2], 2'b00};
        end
        if (q.ap_valid && q.ap_write) begin
            if (q.ap_addr == asp_pkg::CTRL_OFF) begin
                d.rx_done_flag = hwdata[asp_pkg::RX_DONE_POS];
                d.tx_done_flag = hwdata[asp_pkg::TX_DONE_POS];
                d.rx_ninth_bit = hwdata[asp_pkg::RX_NINTH_POS];
                d.cfg.tx_ninth_bit            = hwdata[asp_pkg::TX_NINTH_POS];
                d.cfg.rx_enable               = hwdata[asp_pkg::RX_EN_POS];
                d.cfg.multiproc_filter_enable = hwdata[asp_pkg::FILTER_POS];
                d.cfg.mode = {hwdata[asp_pkg::MODE_HI_POS], hwdata[asp_pkg::MODE_LO_POS]};
                d.cfg.baud_double            = hwdata[asp_pkg::BAUD_DBL_POS];
                d.cfg.tx_clock_source_select = hwdata[asp_pkg::TX_SRC_POS];
                d.cfg.rx_clock_source_select = hwdata[asp_pkg::RX_SRC_POS];
            end else if (q.ap_addr == asp_pkg::BAUD_OFF) begin
                d.div_t1 = hwdata[DIV_W-1:0];
                d.div_t2 = hwdata[16+DIV_W-1:16];
            end
        end
        if (d.ap_valid && !hwrite) begin
            if (haddr[7:0] == asp_pkg::CTRL_OFF) begin
                d.rdata = {21'h0, q.cfg.rx_clock_source_select, q.cfg.tx_clock_source_select,
                           q.cfg.baud_double, q.cfg.mode,
                           q.cfg.multiproc_filter_enable, q.cfg.rx_enable,
                           q.cfg.tx_ninth_bit, q.rx_ninth_bit, q.tx_done_flag,
                           q.rx_done_flag};
            end else if (haddr[7:0] == asp_pkg::BUF_OFF) begin
                d.rdata = {24'h0, q.serial_buffer};
            end else if (haddr[7:0] == asp_pkg::BAUD_OFF) begin
                d.rdata = {q.div_t2, q.div_t1};
            end else if (haddr[7:0] == asp_pkg::STAT_OFF) begin
                d.rdata = {26'h0, q.rx_st, q.tx_st, q.txd, q.rx_s2};
            end else begin
                d.rdata = 32'h0;
            end
        end

        // Transmitter
        if (wr_buf && mode_on) begin
            d.tx_sh  = {eleven ? q.cfg.tx_ninth_bit : 1'b1, hwdata[7:0]};
            d.tx_req = 1'b1;
        end
        if (tx_tick) begin
            d.tx_cnt = q.tx_cnt + 4'h1;
        end
        case (q.tx_st)
            TX_IDLE: begin
                d.txd = 1'b1;
                if (q.tx_req) begin
                    d.tx_st = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (tx_tick && q.tx_cnt == 4'hf) begin
                    d.tx_st  = TX_START;
                    d.txd    = 1'b0;
                    d.tx_req = 1'b0;
                end
            end
            TX_START: begin
                if (tx_tick && q.tx_cnt == 4'hf) begin
                    d.tx_st    = TX_DATA;
                    d.tx_first = 1'b1;
                    d.txd      = q.tx_sh[0];
                end
            end
            default: begin
                if (tx_tick && q.tx_cnt == 4'hf) begin
                    d.tx_first = 1'b0;
                    // Before its first shift an 11-bit word may mimic the end pattern
                    if (!(eleven && q.tx_first) && q.tx_sh[8:1] == 8'h01) begin
                        d.tx_sh        = 9'h0;
                        d.txd          = 1'b1;
                        d.tx_st        = TX_IDLE;
                        d.tx_done_flag = 1'b1;
                    end else begin
                        // Stop bit one enters on the first shift only in 11-bit modes
                        d.tx_sh = {eleven && q.tx_first, q.tx_sh[8:1]};
                        d.txd   = q.tx_sh[1];
                    end
                end
            end
        endcase

        // Receiver
        if (rx_tick) begin
            d.rx_cnt = q.rx_cnt + 4'h1;
            if (q.rx_cnt >= asp_pkg::SAMPLE_A && q.rx_cnt <= asp_pkg::SAMPLE_C) begin
                d.smp = {q.smp[1:0], q.rx_s2};
            end
        end
        case (q.rx_st)
            RX_HUNT: begin
                if (mode_on && q.cfg.rx_enable && q.rx_prev && !q.rx_s2) begin
                    d.rx_sh  = asp_pkg::RX_SHIFT_INIT;
                    d.rx_cnt = 4'h0;
                    d.rx_st  = RX_BITS;
                end
            end
            RX_BITS: begin
                if (rx_tick && q.rx_cnt == 4'hf) begin
                    if (q.rx_sh == asp_pkg::RX_SHIFT_INIT && rx_bit) begin
                        d.rx_st = RX_HUNT;
                    end else if (!q.rx_sh[8]) begin
                        d.rx_sh = {q.rx_sh[7:0], rx_bit};
                        d.rx_st = RX_TAIL;
                        // Final shift: in 10-bit mode the incoming bit is the stop bit
                        if (commit) begin
                            d.rx_ninth_bit  = rx_bit;
                            d.serial_buffer = rx_rev;
                            d.rx_done_flag  = 1'b1;
                        end
                        if (!eleven) begin
                            d.rx_st = RX_HUNT;
                        end
                    end else begin
                        d.rx_sh = {q.rx_sh[7:0], rx_bit};
                    end
                end
            end
            default: begin
                if (rx_tick && q.rx_cnt == 4'hf) begin
                    d.rx_st = RX_HUNT;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q         <= '0;
            q.cfg     <= asp_pkg::asp_cfg_s'(asp_pkg::CTRL_RST[7:0]);
            q.div_t1  <= asp_pkg::DIV_RST[DIV_W-1:0];
            q.div_t2  <= asp_pkg::DIV_RST[DIV_W-1:0];
            q.tx_st   <= TX_IDLE;
            q.rx_st   <= RX_HUNT;
            q.txd     <= 1'b1;
            q.rx_s1   <= 1'b1;
            q.rx_s2   <= 1'b1;
            q.rx_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata    = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign txd_pin   = q.txd;
endmodule : asp_core
`default_nettype wire

/* test/asp_core_props.sv */
// Checker for the serial port core: bus answers and transmit framing
// Assumes the transmit tick comes every two cycles, so a bit lasts 32 cycles, or 64 in slow fixed mode
`timescale 1ns/10ps
`default_nettype none
module asp_core_props (
    input wire logic        hclk,      // Clock
    input wire logic        hresetn,   // Reset, active low
    input wire logic        hsel,      // Select
    input wire logic [31:0] haddr,     // Address
    input wire logic [1:0]  htrans,    // Transfer type
    input wire logic        hwrite,    // Write
    input wire logic        hready,    // Bus ready
    input wire logic [31:0] hwdata,    // Write data
    input wire logic [31:0] hrdata,    // Read data
    input wire logic        hreadyout, // Slave ready
    input wire logic        hresp,     // Response
    input wire logic        txd_pin    // Serial output
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] mode_q;
    logic       dbl_q, t9_q, ctrl_q, buf_q, txd_q, busy_q;
    logic [9:0] cyc_q;
    wire logic       acc_w  = hsel && hready && htrans[1];
    wire logic [9:0] bit_w  = (mode_q == 2'b10 && !dbl_q) ? 10'h040 : 10'h020;
    wire logic [9:0] stop_w = (mode_q[1] ? 10'h00a : 10'h009) * bit_w + (bit_w >> 1);
    ////////////////////////////////////////
    // Tracks the settings written and the cycle position inside a sent frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {mode_q, dbl_q, t9_q, ctrl_q, buf_q, busy_q} <= '0;
            txd_q <= 1'b1;
            cyc_q <= '0;
        end else begin
            ctrl_q <= acc_w && hwrite && haddr[7:0] == asp_pkg::CTRL_OFF;
            buf_q <= acc_w && hwrite && haddr[7:0] == asp_pkg::BUF_OFF;
            if (ctrl_q) {dbl_q, mode_q, t9_q} <= {hwdata[8:6], hwdata[3]};
            txd_q <= txd_pin;
            cyc_q <= busy_q ? cyc_q + 10'h001 : 10'h000;
            if (!busy_q && txd_q && !txd_pin) busy_q <= 1'b1;
            else if (cyc_q == stop_w) busy_q <= 1'b0;
        end
    end
    ////////////////////////////////////////
    sequence s_tx_begin;
        ##[1:72] $fell(txd_pin);
    endsequence
    property p_tx_start_delay;
        buf_q && mode_q != 2'b00 && !busy_q && txd_pin |-> s_tx_begin;
    endproperty
    a_tx_start_delay: assert property (p_tx_start_delay) else $error("no frame after write");
    property p_tx_start_bit;
        busy_q && cyc_q == (bit_w >> 1) - 10'h001 |-> !txd_pin;
    endproperty
    a_tx_start_bit: assert property (p_tx_start_bit) else $error("start bit not low");
    property p_tx_stop10;
        busy_q && !mode_q[1] && cyc_q == stop_w - 10'h001 |-> txd_pin;
    endproperty
    a_tx_stop10: assert property (p_tx_stop10) else $error("short frame stop low");
    property p_tx_stop11;
        busy_q && mode_q[1] && cyc_q == stop_w - 10'h001 |-> txd_pin;
    endproperty
    a_tx_stop11: assert property (p_tx_stop11) else $error("long frame stop low");
    property p_tx_ninth;
        busy_q && mode_q[1] && cyc_q == stop_w - bit_w - 10'h001 |-> txd_pin == t9_q;
    endproperty
    a_tx_ninth: assert property (p_tx_ninth) else $error("ninth bit wrong");
    property p_shift_quiet;
        mode_q == 2'b00 && !busy_q |-> txd_pin [*2];
    endproperty
    a_shift_quiet: assert property (p_shift_quiet) else $error("line moved in mode 00");
    property p_ctrl_read;
        acc_w && !hwrite && haddr[7:0] == asp_pkg::CTRL_OFF |=> hrdata[8:6] == {dbl_q, mode_q};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("mode readback wrong");
    property p_unmapped;
        acc_w && !hwrite && haddr[7:0] == 8'h10 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus wait or error");
endmodule : asp_core_props
bind asp_core asp_core_props asp_core_props_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .txd_pin);
`default_nettype wire

/* test/asp_remote.sv */
// Remote serial device: sends frames into the port, samples frames coming out
// Assumes its tasks are called right after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module asp_remote (
    input  wire logic hclk,    // Clock
    input  wire logic txd_pin, // Line from the port
    output logic      rxd_pin  // Line into the port, idle high
);
    initial rxd_pin = 1'b1;
    // Bit 0 is the start bit; bits leave in index order
    task automatic send(input logic [10:0] bits, input int n, input int bitc);
        for (int i = 0; i < n; i++) begin
            rxd_pin <= bits[i];
            repeat (bitc) @(posedge hclk);
        end
        rxd_pin <= 1'b1;
    endtask : send
    task automatic glitch(input int c);
        rxd_pin <= 1'b0;
        repeat (c) @(posedge hclk);
        rxd_pin <= 1'b1;
    endtask : glitch
    // Samples each bit at its centre; a missing frame reads as all ones
    task automatic capture(input int n, input int bitc, output logic [10:0] bits);
        int w;
        bits = '1;
        for (w = 0; w < 200 && txd_pin !== 1'b0; w++) @(posedge hclk);
        repeat (bitc / 2) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            bits[i] = txd_pin;
            repeat (bitc) @(posedge hclk);
        end
    endtask : capture
endmodule : asp_remote
`default_nettype wire

/* test/asp_core_tb_top.sv */
// Testbench for the serial port core: register bus, send and receive paths
// Assumes the remote model on the serial lines and a 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
module asp_core_tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, rxd_pin, txd_pin;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d = 32'h0;
    logic [10:0] f;
    int          fails = 0, comparisons = 0;
    always #50 hclk = ~hclk;
    asp_core asp_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .rxd_pin, .txd_pin);
    asp_remote asp_remote_i (.hclk, .txd_pin, .rxd_pin);
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus
    function automatic logic [31:0] cfg(input logic [1:0] m, input logic t9, ren, filt, dbl, src);
        return {21'h0, src, src, dbl, m, filt, ren, t9, 3'h0};
    endfunction : cfg
    task automatic summarize;
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    task automatic t_reset;
        bus(1'b0, asp_pkg::CTRL_OFF, 32'h0);
        check("ctrl reset", d, {21'h0, asp_pkg::CTRL_RST});
        bus(1'b0, asp_pkg::BAUD_OFF, 32'h0);
        check("reload reset", d, {2{asp_pkg::DIV_RST}});
        bus(1'b1, asp_pkg::BAUD_OFF, 32'h0001_0001);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", d, 32'h0);
    endtask : t_reset
    task automatic t_tx(input logic [1:0] m, input logic t9, dbl, src, input int bitc,
                        input logic [7:0] v);
        bus(1'b1, asp_pkg::CTRL_OFF, cfg(m, t9, 1'b0, 1'b0, dbl, src));
        bus(1'b1, asp_pkg::BUF_OFF, {24'h0, v});
        asp_remote_i.capture(m[1] ? 11 : 10, bitc, f);
        check("tx frame", m[1] ? {21'h0, f} : {22'h0, f[9:0]},
              m[1] ? {21'h0, 1'b1, t9, v, 1'b0} : {22'h0, 1'b1, v, 1'b0});
        d = 32'h0;
        for (int i = 0; i < 40 && d[1] !== 1'b1; i++) bus(1'b0, asp_pkg::CTRL_OFF, 32'h0);
        check("tx done", {31'h0, d[1]}, 32'h1);
        bus(1'b1, asp_pkg::CTRL_OFF, cfg(m, t9, 1'b0, 1'b0, dbl, src));
        bus(1'b0, asp_pkg::CTRL_OFF, 32'h0);
        check("tx done clear", {31'h0, d[1]}, 32'h0);
    endtask : t_tx
    task automatic t_rx(input logic [1:0] m, input logic clr, filt, ren, input logic [10:0] fr,
                        input logic [2:0] e, input logic [7:0] ev);
        if (clr) bus(1'b1, asp_pkg::CTRL_OFF, cfg(m, 1'b0, ren, filt, 1'b1, 1'b0));
        asp_remote_i.send(fr, m[1] ? 11 : 10, 32);
        repeat (8) @(posedge hclk);
        bus(1'b0, asp_pkg::CTRL_OFF, 32'h0);
        check("rx flags", {29'h0, d[2:0]}, {29'h0, e});
        bus(1'b0, asp_pkg::BUF_OFF, 32'h0);
        check("rx data", {24'h0, d[7:0]}, {24'h0, ev});
    endtask : t_rx
    task automatic t_shift;
        bus(1'b1, asp_pkg::CTRL_OFF, cfg(2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        bus(1'b1, asp_pkg::BUF_OFF, 32'h77);
        repeat (80) @(posedge hclk);
        bus(1'b0, asp_pkg::CTRL_OFF, 32'h0);
        check("shift mode idle", {31'h0, d[1]}, 32'h0);
    endtask : t_shift
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_tx(2'b01, 1'b0, 1'b0, 1'b0, 32, 8'ha5);
        t_tx(2'b10, 1'b1, 1'b1, 1'b0, 32, 8'h5a);
        t_tx(2'b10, 1'b0, 1'b0, 1'b0, 64, 8'h81);
        bus(1'b1, asp_pkg::BAUD_OFF, 32'h0001_0003);
        t_tx(2'b11, 1'b1, 1'b0, 1'b1, 32, 8'h3c);
        bus(1'b1, asp_pkg::BAUD_OFF, 32'h0001_0001);
        t_rx(2'b01, 1'b1, 1'b0, 1'b1, {2'b11, 8'h3c, 1'b0}, 3'b101, 8'h3c);
        t_rx(2'b01, 1'b0, 1'b0, 1'b1, {2'b11, 8'hc3, 1'b0}, 3'b101, 8'h3c);
        t_rx(2'b01, 1'b1, 1'b1, 1'b1, {2'b10, 8'hc3, 1'b0}, 3'b000, 8'h3c);
        asp_remote_i.glitch(6);
        repeat (60) @(posedge hclk);
        t_rx(2'b01, 1'b1, 1'b0, 1'b1, {2'b11, 8'h96, 1'b0}, 3'b101, 8'h96);
        t_rx(2'b10, 1'b1, 1'b1, 1'b1, {2'b10, 8'h11, 1'b0}, 3'b000, 8'h96);
        t_rx(2'b10, 1'b1, 1'b1, 1'b1, {2'b11, 8'h22, 1'b0}, 3'b101, 8'h22);
        t_rx(2'b11, 1'b1, 1'b0, 1'b1, {2'b00, 8'h44, 1'b0}, 3'b001, 8'h44);
        t_rx(2'b01, 1'b1, 1'b0, 1'b0, {2'b11, 8'h55, 1'b0}, 3'b000, 8'h44);
        t_shift();
        summarize();
    end
    initial begin
        #(100 * 40000);
        fails++;
        summarize();
    end
endmodule : asp_core_tb_top
`default_nettype wire
